// File: design/pdm_pkg.sv
// Purpose: constants for the port d pin function multiplexer
// Assumes: classic wishbone slave, 32-bit data, byte addresses
// Notes:   register offsets are byte addresses of aligned words
package pdm_pkg;
    localparam int unsigned PDM_PORT_W      = 8;          // pins on the port
    localparam int unsigned PDM_ADR_W       = 4;          // decoded address bits
    localparam logic [3:0]  PDM_OFF_LEVEL   = 4'h0;       // pin_level_reg
    localparam logic [3:0]  PDM_OFF_LATCH   = 4'h4;       // output_latch_reg
    localparam logic [3:0]  PDM_OFF_DIR     = 4'h8;       // pin_direction_bits
    localparam logic [3:0]  PDM_OFF_CTRL    = 4'hc;       // control word
    localparam logic [7:0]  PDM_DIR_RST     = 8'hff;      // all inputs at reset
    localparam logic [7:0]  PDM_LATCH_RST   = 8'h00;      // latch reset value
    localparam int unsigned PDM_CTRL_DIS    = 0;          // memory_bus_disable_bit
    localparam int unsigned PDM_CTRL_PSEL   = 1;          // parallel_port_pin_select
    localparam logic [1:0]  PDM_CTRL_RST    = 2'h3;       // bus disabled, pmp mapped here
    localparam int unsigned PDM_SDO_PIN     = 4;          // serial data out pin
    localparam int unsigned PDM_SDI_PIN     = 5;          // serial data in / two-wire pin
    typedef enum logic [1:0] {
        PDM_OWN_PORT = 2'b00,
        PDM_OWN_PMP  = 2'b01,
        PDM_OWN_EMB  = 2'b10
    } pdm_own_e;
endpackage

// File: design/pdm_port_mux.sv
// Purpose: pin multiplexer for an 8-bit bidirectional port with wishbone registers
// Assumes: pins are asynchronous to i_clk and pass a two-stage synchroniser
// Notes:   memory bus over parallel port over serial port over latch data
//
// How it works
// - direction one means input, zero drives latch
// - writing level or latch register loads latches
// - memory bus drives address/data ignoring direction
// - memory bus reads take pin levels as data
// - memory bus beats every other pin function
// - memory bus exists only on large package
// - active parallel port drives its data out
// - parallel port reads take pin levels
// - parallel port mapped here when select one
// - pin four direction zero drives serial data
// - pin five direction one feeds serial input
// - pin five carries two-wire data, overrides latch
// - peripheral direction overrides direction bit when don't-care
// - port functions only while memory bus disabled
// - reset makes every pin an input
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
module pdm_port_mux
    import pdm_pkg::*;
#(
    parameter bit LARGE_PKG = 1'b1                       // memory bus bonded out
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    // classic wishbone slave
    input  wire logic                  i_wb_cyc,
    input  wire logic                  i_wb_stb,
    input  wire logic                  i_wb_we,
    input  wire logic [PDM_ADR_W-1:0]  i_wb_adr,
    input  wire logic [3:0]            i_wb_sel,
    input  wire logic [31:0]           i_wb_dat,
    output logic      [31:0]           o_wb_dat,
    output logic                       o_wb_ack,
    // external memory bus side
    input  wire logic                  i_emb_active,     // bus cycle in progress; gates the pin drive with i_emb_oe
    input  wire logic                  i_emb_oe,         // address/data phase outward
    input  wire logic [PDM_PORT_W-1:0] i_emb_ad,
    output logic      [PDM_PORT_W-1:0] o_emb_din,
    // parallel master unit side
    input  wire logic                  i_pmp_active,
    input  wire logic                  i_pmp_oe,
    input  wire logic [PDM_PORT_W-1:0] i_pmp_dout,
    output logic      [PDM_PORT_W-1:0] o_pmp_din,
    // second serial port side
    input  wire logic                  i_ssp_spi_en,     // spi mode drives pin four while direction bit four is zero
    input  wire logic                  i_ssp_sdo,
    output logic                       o_ssp_sdi,
    input  wire logic                  i_ssp_i2c_en,     // two-wire mode owns pin five
    input  wire logic                  i_ssp_sda_oe,     // drive i_ssp_sda_out on the wire
    input  wire logic                  i_ssp_sda_out,
    output logic                       o_ssp_sda_in,
    // pins, split in three
    input  wire logic [PDM_PORT_W-1:0] i_pin,
    output logic      [PDM_PORT_W-1:0] o_pin,
    output logic      [PDM_PORT_W-1:0] o_pin_oe
);

    logic [PDM_PORT_W-1:0] pin_meta_r;                   // first synchroniser stage
    logic [PDM_PORT_W-1:0] pin_sync_r;                   // usable pin levels
    logic [PDM_PORT_W-1:0] latch_r;                      // output_latch_reg
    logic [PDM_PORT_W-1:0] dir_r;                        // pin_direction_bits
    logic [1:0]            ctrl_r;                       // disable bit and pin select
    logic                  ack_r;
    logic [31:0]           rdat_r;
    logic [PDM_PORT_W-1:0] pin_nxt;
    logic [PDM_PORT_W-1:0] oe_nxt;
    pdm_own_e              own;
    logic                  req;
    logic                  emb_on;
    logic                  pmp_on;

    // merge a byte write into an 8-bit register by lane 0
    function automatic logic [7:0] lane0(input logic [7:0] old, input logic [3:0] sel,
                                         input logic [31:0] dat);
        lane0 = sel[0] ? dat[7:0] : old;
    endfunction

    // two-flop synchroniser; only the second stage is read
    // the reset value lasts two cycles and never reaches a pin driver
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end else begin
            pin_meta_r <= i_pin;
            pin_sync_r <= pin_meta_r;
        end
    end

    // a new request when no ack is pending, so each access gets one ack
    // a strobe still high during its ack cycle is not taken again; one held a cycle longer is taken as a new request
    assign req = i_wb_cyc && i_wb_stb && !ack_r;

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req;
        end
    end

    // latch writes: both offsets load the same latches
    // a zero through either offset clears every latch at once
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            latch_r <= PDM_LATCH_RST;
        end else if (req && i_wb_we &&
                     (i_wb_adr == PDM_OFF_LEVEL || i_wb_adr == PDM_OFF_LATCH)) begin
            latch_r <= lane0(latch_r, i_wb_sel, i_wb_dat);
        end
    end

    // direction bits, reset to all inputs
    // a one makes the pin an input, so reset leaves the whole port floating
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            dir_r <= PDM_DIR_RST;
        end else if (req && i_wb_we && i_wb_adr == PDM_OFF_DIR) begin
            dir_r <= lane0(dir_r, i_wb_sel, i_wb_dat);
        end
    end

    // control: memory bus disable and parallel port pin select
    // only lane 0 is looked at; the upper control bits read back as zero
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_r <= PDM_CTRL_RST;
        end else if (req && i_wb_we && i_wb_adr == PDM_OFF_CTRL && i_wb_sel[0]) begin
            ctrl_r <= i_wb_dat[1:0];
        end
    end

    // read data, captured with the request; unmapped reads as zero
    // the level read shows synchronised pins, two cycles behind the wire
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rdat_r <= '0;
        end else if (req && !i_wb_we) begin
            case (i_wb_adr)
                PDM_OFF_LEVEL: rdat_r <= {24'h000000, pin_sync_r};
                PDM_OFF_LATCH: rdat_r <= {24'h000000, latch_r};
                PDM_OFF_DIR:   rdat_r <= {24'h000000, dir_r};
                PDM_OFF_CTRL:  rdat_r <= {30'h0, ctrl_r};
                default:       rdat_r <= '0;
            endcase
        end
    end

    // ownership: bus enabled on the large package wins, then parallel port
    // limitation: the small package never enables the bus, whatever the control bit says
    assign emb_on = LARGE_PKG && !ctrl_r[PDM_CTRL_DIS];
    assign pmp_on = ctrl_r[PDM_CTRL_PSEL] && i_pmp_active;

    always_comb begin
        if (emb_on) begin
            own = PDM_OWN_EMB;
        end else if (pmp_on) begin
            own = PDM_OWN_PMP;
        end else begin
            own = PDM_OWN_PORT;
        end
    end

    // next pin drive; memory bus, parallel port and two-wire direction replace the direction bits
    // trade-off: the output stage adds a cycle of latency but keeps pins glitch free
    always_comb begin
        pin_nxt = latch_r;
        oe_nxt  = ~dir_r;
        case (own)
            PDM_OWN_EMB: begin
                pin_nxt = i_emb_ad;
                oe_nxt  = {PDM_PORT_W{i_emb_active && i_emb_oe}};
            end
            PDM_OWN_PMP: begin
                pin_nxt = i_pmp_dout;
                oe_nxt  = {PDM_PORT_W{i_pmp_oe}};
            end
            PDM_OWN_PORT: begin
                if (i_ssp_spi_en && !dir_r[PDM_SDO_PIN]) begin
                    pin_nxt[PDM_SDO_PIN] = i_ssp_sdo;
                end
                if (i_ssp_i2c_en) begin
                    // open-drain style: only drive when the module asks
                    pin_nxt[PDM_SDI_PIN] = i_ssp_sda_out;
                    oe_nxt[PDM_SDI_PIN]  = i_ssp_sda_oe;
                end
            end
            default: begin
                pin_nxt = latch_r;
                oe_nxt  = '0;
            end
        endcase
    end

    // registered pin drive and peripheral inputs
    // peripheral inputs read as zero while another function owns the pins
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pin        <= '0;
            o_pin_oe     <= '0;
            o_emb_din    <= '0;
            o_pmp_din    <= '0;
            o_ssp_sdi    <= 1'b0;
            o_ssp_sda_in <= 1'b0;
        end else begin
            o_pin        <= pin_nxt;
            o_pin_oe     <= oe_nxt;
            o_emb_din    <= emb_on ? pin_sync_r : '0;
            o_pmp_din    <= (own == PDM_OWN_PMP) ? pin_sync_r : '0;
            o_ssp_sdi    <= (own == PDM_OWN_PORT) && dir_r[PDM_SDI_PIN] && pin_sync_r[PDM_SDI_PIN];
            o_ssp_sda_in <= (own == PDM_OWN_PORT) && pin_sync_r[PDM_SDI_PIN];
        end
    end

    assign o_wb_ack = ack_r;
    assign o_wb_dat = rdat_r;

    // assertions on what this block drives; all sample on i_clk and are
    // masked while reset is high, except the one that watches reset release
    sequence s_req_write_latch;
        req && i_wb_we && i_wb_adr == PDM_OFF_LEVEL && i_wb_sel[0];
    endsequence

    // the second alias of the latches, reached through its own offset
    sequence s_req_write_alias;
        req && i_wb_we && i_wb_adr == PDM_OFF_LATCH && i_wb_sel[0];
    endsequence

    // a write with lane 0 off must leave every register alone
    sequence s_req_write_nolane;
        req && i_wb_we && !i_wb_sel[0];
    endsequence

    sequence s_req_read_level;
        req && !i_wb_we && i_wb_adr == PDM_OFF_LEVEL;
    endsequence

    sequence s_req_read_latch;
        req && !i_wb_we && i_wb_adr == PDM_OFF_LATCH;
    endsequence

    a_level_write_latch: assert property (@(posedge i_clk) disable iff (i_rst)
        s_req_write_latch |=> latch_r == $past(i_wb_dat[7:0]))
        else $error("level write did not load latches");

    a_port_dir_drive: assert property (@(posedge i_clk) disable iff (i_rst)
        own == PDM_OWN_PORT && !i_ssp_i2c_en |=> o_pin_oe == ~$past(dir_r))
        else $error("port direction not honoured");

    a_emb_drives_ad: assert property (@(posedge i_clk) disable iff (i_rst)
        emb_on && i_emb_active && i_emb_oe |=> o_pin == $past(i_emb_ad) && &o_pin_oe)
        else $error("memory bus not driving pins");

    a_emb_read_data: assert property (@(posedge i_clk) disable iff (i_rst)
        emb_on |=> o_emb_din == $past(pin_sync_r))
        else $error("memory bus read data wrong");

    a_emb_priority: assert property (@(posedge i_clk) disable iff (i_rst)
        emb_on |-> own == PDM_OWN_EMB)
        else $error("memory bus lost priority");

    a_small_no_emb: assert property (@(posedge i_clk) disable iff (i_rst)
        !LARGE_PKG |-> !emb_on)
        else $error("memory bus on small package");

    a_pmp_drive: assert property (@(posedge i_clk) disable iff (i_rst)
        own == PDM_OWN_PMP && i_pmp_oe |=> o_pin == $past(i_pmp_dout) && &o_pin_oe)
        else $error("parallel port not driving");

    a_pmp_read: assert property (@(posedge i_clk) disable iff (i_rst)
        own == PDM_OWN_PMP |=> o_pmp_din == $past(pin_sync_r))
        else $error("parallel port read wrong");

    a_sdo_drive: assert property (@(posedge i_clk) disable iff (i_rst)
        own == PDM_OWN_PORT && i_ssp_spi_en && !dir_r[PDM_SDO_PIN]
        |=> o_pin[PDM_SDO_PIN] == $past(i_ssp_sdo) && o_pin_oe[PDM_SDO_PIN])
        else $error("serial data out not on pin four");

    a_ack_one_cycle: assert property (@(posedge i_clk) disable iff (i_rst)
        o_wb_ack |=> !o_wb_ack)
        else $error("ack held too long");

    a_ack_follows_req: assert property (@(posedge i_clk) disable iff (i_rst)
        req |=> o_wb_ack)
        else $error("request not acknowledged");

    a_alias_write_latch: assert property (@(posedge i_clk) disable iff (i_rst)
        s_req_write_alias |=> latch_r == $past(i_wb_dat[PDM_PORT_W-1:0]))
        else $error("latch write did not load latches");

    a_nolane_ignored: assert property (@(posedge i_clk) disable iff (i_rst)
        s_req_write_nolane |=> $stable(latch_r) && $stable(dir_r) && $stable(ctrl_r))
        else $error("write without lane 0 changed a register");

    a_read_level_pins: assert property (@(posedge i_clk) disable iff (i_rst)
        s_req_read_level |=> o_wb_dat[PDM_PORT_W-1:0] == $past(pin_sync_r) && o_wb_dat[31:PDM_PORT_W] == '0)
        else $error("level read not showing pins");

    a_read_latch_value: assert property (@(posedge i_clk) disable iff (i_rst)
        s_req_read_latch |=> o_wb_dat[PDM_PORT_W-1:0] == $past(latch_r) && o_wb_dat[31:PDM_PORT_W] == '0)
        else $error("latch read not showing latches");

    a_port_latch_drive: assert property (@(posedge i_clk) disable iff (i_rst)
        own == PDM_OWN_PORT && !i_ssp_spi_en && !i_ssp_i2c_en |=> o_pin == $past(latch_r))
        else $error("port pins not showing latch data");

    a_emb_floats_idle: assert property (@(posedge i_clk) disable iff (i_rst)
        own == PDM_OWN_EMB && !(i_emb_active && i_emb_oe) |=> o_pin_oe == '0)
        else $error("memory bus pins driven while idle");

    a_emb_blocks_others: assert property (@(posedge i_clk) disable iff (i_rst)
        emb_on |=> o_pmp_din == '0 && !o_ssp_sdi && !o_ssp_sda_in)
        else $error("other function saw pins under memory bus");

    a_pmp_release: assert property (@(posedge i_clk) disable iff (i_rst)
        own == PDM_OWN_PMP && !i_pmp_oe |=> o_pin_oe == '0)
        else $error("parallel port pins driven while reading");

    a_pmp_unmapped: assert property (@(posedge i_clk) disable iff (i_rst)
        !emb_on && !ctrl_r[PDM_CTRL_PSEL] |=> o_pmp_din == '0)
        else $error("parallel port fed while not mapped");

    a_sdi_feed: assert property (@(posedge i_clk) disable iff (i_rst)
        own == PDM_OWN_PORT && dir_r[PDM_SDI_PIN] |=> o_ssp_sdi == $past(pin_sync_r[PDM_SDI_PIN]))
        else $error("serial data in not fed from pin five");

    a_sdi_blocked: assert property (@(posedge i_clk) disable iff (i_rst)
        !dir_r[PDM_SDI_PIN] |=> !o_ssp_sdi)
        else $error("serial data in fed from an output pin");

    a_sda_drive: assert property (@(posedge i_clk) disable iff (i_rst)
        own == PDM_OWN_PORT && i_ssp_i2c_en
        |=> o_pin[PDM_SDI_PIN] == $past(i_ssp_sda_out) && o_pin_oe[PDM_SDI_PIN] == $past(i_ssp_sda_oe))
        else $error("two-wire data not on pin five");

    a_sda_input: assert property (@(posedge i_clk) disable iff (i_rst)
        own == PDM_OWN_PORT |=> o_ssp_sda_in == $past(pin_sync_r[PDM_SDI_PIN]))
        else $error("two-wire input not fed from pin five");

    a_reset_inputs: assert property (@(posedge i_clk)
        $fell(i_rst) |-> o_pin_oe == '0)
        else $error("pins driven on reset release");

endmodule

// File: tb/pdm_board_model.sv
// Purpose: board circuit hung on the eight port pins
// Assumes: each pin is sourced weakly by the board
// Notes:   the chip's driver wins wherever its enable is high
`timescale 1ns/100ps
module pdm_board_model (
    input  wire logic [7:0] i_pin_drv,  // chip drive value
    input  wire logic [7:0] i_pin_oe,   // chip drive enable
    input  wire logic [7:0] i_ext,      // weak board source
    output logic      [7:0] o_level     // resolved wire level
);
    // a weak source never floats, so no unknown reaches the synchroniser
    always_comb begin
        o_level = (i_pin_oe & i_pin_drv) | (~i_pin_oe & i_ext);
    end
endmodule

// File: tb/pdm_port_mux_test.sv
// Purpose: self-checking bench for the port pin multiplexer
// Assumes: one ack per request, pins reach reads within a few edges
// Notes:   waits of five edges cover the synchroniser and output flops
`timescale 1ns/100ps
module pdm_port_mux_test;
    import pdm_pkg::*;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0;   // clock, reset, bus strobes
    logic [3:0]  adr = 0;                              // byte address
    logic [3:0]  sel = 4'h1;                           // byte lanes
    logic [31:0] wdat = 0, rdat;                       // bus data
    logic ack, sdi, sda_in;                            // design answers
    logic emb_act = 0, emb_oe = 0, pmp_act = 0, pmp_oe = 0;
    logic spi_en = 0, sdo = 0, i2c_en = 0, sda_oe = 0, sda_out = 0;
    logic [7:0] emb_ad = 0, pmp_dout = 0, ext = 0;     // peripheral data, board source
    logic [7:0] emb_din, pmp_din, pin_lvl, pin_out, pin_oe;
    int n_mismatch = 0, num_checks = 0;
    // 125 MHz clock
    always #4 clk = ~clk;
    pdm_port_mux pdm_port_mux_i (.i_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
        .o_wb_ack(ack), .i_emb_active(emb_act), .i_emb_oe(emb_oe), .i_emb_ad(emb_ad),
        .o_emb_din(emb_din), .i_pmp_active(pmp_act), .i_pmp_oe(pmp_oe), .i_pmp_dout(pmp_dout),
        .o_pmp_din(pmp_din), .i_ssp_spi_en(spi_en), .i_ssp_sdo(sdo), .o_ssp_sdi(sdi),
        .i_ssp_i2c_en(i2c_en), .i_ssp_sda_oe(sda_oe), .i_ssp_sda_out(sda_out),
        .o_ssp_sda_in(sda_in), .i_pin(pin_lvl), .o_pin(pin_out), .o_pin_oe(pin_oe));
    pdm_board_model pdm_board_model_i (.i_pin_drv(pin_out), .i_pin_oe(pin_oe), .i_ext(ext),
        .o_level(pin_lvl));
    // compare and count
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one classic cycle; ack is taken at the edge where it is seen high
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int n = 0;
        @(posedge clk);
        cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
            print_verdict;
        end
        q = rdat;
        cyc <= 0; stb <= 0; we <= 0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1, a, {24'h0, d}, q);
    endtask
    task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(0, a, 0, q);
        chk(nm, q, exp);
    endtask
    // let drivers, synchroniser and output flops land
    task automatic settle;
        repeat (5) @(posedge clk);
    endtask
    task automatic t_reset;
        chk("oe", pin_oe, 0);
        rdc("dir", PDM_OFF_DIR, 32'hff);
        rdc("latch", PDM_OFF_LATCH, 0);
        rdc("ctrl", PDM_OFF_CTRL, 32'h3);
        $display("reset test done");
    endtask
    task automatic t_port;
        ext <= 8'h3c;
        wr(PDM_OFF_LATCH, 8'ha5);
        wr(PDM_OFF_DIR, 8'h0f);
        settle;
        chk("oe", pin_oe, 32'hf0);
        chk("out", pin_out[7:4], 32'ha);
        rdc("level", PDM_OFF_LEVEL, 32'hac);
        rdc("latch", PDM_OFF_LATCH, 32'ha5);
        wr(PDM_OFF_LEVEL, 0);
        settle;
        chk("out", pin_out, 0);
        wr(PDM_OFF_LATCH, 8'hff);
        wr(PDM_OFF_LATCH, 0);
        rdc("latch", PDM_OFF_LATCH, 0);
        sel <= 4'h0;
        wr(PDM_OFF_LATCH, 8'h77);
        sel <= 4'h1;
        rdc("nolane", PDM_OFF_LATCH, 0);
        rdc("hole", 4'h2, 0);
        $display("port test done");
    endtask
    task automatic t_pmp;
        wr(PDM_OFF_DIR, 8'hff);
        pmp_act <= 1; pmp_oe <= 1; pmp_dout <= 8'h96;
        settle;
        chk("oe", pin_oe, 32'hff);
        chk("out", pin_out, 32'h96);
        pmp_oe <= 0; ext <= 8'h5a;
        settle;
        chk("pdin", pmp_din, 32'h5a);
        pmp_oe <= 1;
        wr(PDM_OFF_CTRL, 8'h1);
        settle;
        chk("oe", pin_oe, 0);
        pmp_act <= 0; pmp_oe <= 0;
        wr(PDM_OFF_CTRL, 8'h3);
        $display("parallel test done");
    endtask
    task automatic t_ssp;
        wr(PDM_OFF_DIR, 8'hef);
        spi_en <= 1; sdo <= 1; ext <= 8'h20;
        settle;
        chk("sdo", pin_out[4], 1);
        chk("sdi", sdi, 1);
        i2c_en <= 1; sda_oe <= 1; sda_out <= 0;
        settle;
        chk("oe5", pin_oe[5], 1);
        chk("sda", pin_out[5], 0);
        sda_oe <= 0;
        settle;
        chk("sdain", sda_in, 1);
        spi_en <= 0; i2c_en <= 0;
        $display("serial test done");
    endtask
    task automatic t_emb;
        wr(PDM_OFF_CTRL, 8'h2);
        pmp_act <= 1; pmp_oe <= 1; emb_act <= 1; emb_oe <= 1; emb_ad <= 8'h3c;
        settle;
        chk("out", pin_out, 32'h3c);
        chk("oe", pin_oe, 32'hff);
        emb_oe <= 0; ext <= 8'hc3;
        settle;
        chk("edin", emb_din, 32'hc3);
        chk("pdin", pmp_din, 0);
        emb_act <= 0; pmp_act <= 0; pmp_oe <= 0;
        wr(PDM_OFF_CTRL, 8'h3);
        $display("memory bus test done");
    endtask
    // reset in mid-run, with pin four driving, must float every pin again
    task automatic t_rerst;
        rst <= 1;
        repeat (2) @(posedge clk);
        chk("oe", pin_oe, 0);
        rst <= 0;
        rdc("dir", PDM_OFF_DIR, 32'hff);
        $display("mid-run reset test done");
    endtask
    // single closing point of the run
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // main sequence: reset for three cycles, then each scenario in turn
    initial begin
        repeat (3) @(posedge clk);
        rst <= 0;
        t_reset;
        t_port;
        t_pmp;
        t_ssp;
        t_emb;
        t_rerst;
        print_verdict;
    end
    // watchdog well past the roughly 120 cycles the tests need
    initial begin
        #200000;
        n_mismatch++;
        print_verdict;
    end
endmodule
